// ===== flh_fault_log.sv
// Purpose: forced fault log store, erase, and block read header
// Assumes: command decoder delivers one-cycle strobes with the code
// Notes: cyclical pages after byte 19 come from the event_byte_i port
`timescale 1ns/100ps
`include "flh_defines.svh"
module flh_fault_log #(
	parameter int TICK_CYC = `FLH_TICK_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// command strobes from the bus decoder
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic cmd_has_data_i,
	// read byte handshake
	input wire logic rd_next_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic rd_last_o,
	// configuration and telemetry
	input wire logic [7:0] global_config_word_i,
	input wire logic signed [15:0] die_temp_c_i,
	input wire logic real_fault_i,
	input wire logic [7:0] fault_pos_i,
	input wire logic [15:0] output_voltage_peak_i,
	input wire logic [15:0] output_current_peak_i,
	input wire logic [15:0] channel_input_current_peak_i,
	input wire logic [15:0] input_voltage_peak_i,
	input wire logic [15:0] ext_temp_i,
	input wire logic [7:0] event_byte_i,
	// status and storage requests
	input wire logic status_clear_i,
	output logic status_store_bit_o,
	output logic nvm_store_o,
	output logic nvm_erase_o,
	output logic log_present_o,
	output logic hot_lockout_o,
	output logic [7:0] event_index_o
);
	import flh_pkg::*;

	typedef struct packed {
		flh_rd_e rd;
		logic [7:0] idx;
		logic [7:0] dout;
		logic present;
		logic hot;
		logic stat;
		logic store;
		logic erase;
		flh_snap_s snap;
	} flh_st_s;

	flh_st_s st;
	flh_st_s next_st;
	flh_uptime_if up_if ();

	flh_uptime #(
		.TICK_CYC(TICK_CYC)
	) u_uptime (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.up(up_if.src)
	);

	initial begin
		if (TICK_CYC < 1) $error("tick count must be at least one");
	end

	// header byte by number; gaps and byte 19 read zero
	function automatic logic [7:0] hdr_byte(input flh_snap_s s, input logic [7:0] n);
		logic [7:0] b;
		b = 8'h00;
		case (n)
			8'h00: b = s.fault_pos;
			8'h01: b = s.uptime[7:0];
			8'h02: b = s.uptime[15:8];
			8'h03: b = s.uptime[23:16];
			8'h04: b = s.uptime[31:24];
			8'h05: b = s.uptime[39:32];
			8'h06: b = s.uptime[47:40];
			8'h07: b = s.vout_pk[15:8];
			8'h08: b = s.vout_pk[7:0];
			8'h0B: b = s.iout_pk[15:8];
			8'h0C: b = s.iout_pk[7:0];
			8'h0D: b = s.iin_pk[15:8];
			8'h0E: b = s.iin_pk[7:0];
			8'h0F: b = s.vin_pk[15:8];
			8'h10: b = s.vin_pk[7:0];
			8'h11: b = s.temp_ext[15:8];
			8'h12: b = s.temp_ext[7:0];
			default: b = 8'h00;
		endcase
		return b;
	endfunction : hdr_byte

	function automatic logic [7:0] pick_byte(input flh_snap_s s, input logic [7:0] n,
		input logic [7:0] ev);
		logic [7:0] b;
		b = (n <= `FLH_HDR_LAST) ? hdr_byte(s, n) : ev;
		return b;
	endfunction : pick_byte

	logic store_req;
	logic erase_req;
	logic read_req;

	assign store_req = cmd_valid_i && !cmd_has_data_i && cmd_code_i == `FLH_CMD_FORCE_STORE;
	assign erase_req = cmd_valid_i && !cmd_has_data_i && cmd_code_i == `FLH_CMD_ERASE;
	assign read_req = cmd_valid_i && cmd_code_i == `FLH_CMD_BLOCK_READ;

	always_comb begin
		next_st = st;
		next_st.store = 1'b0;
		next_st.erase = 1'b0;
		if (die_temp_c_i > `FLH_TEMP_HI_C) begin
			next_st.hot = 1'b1;
		end else if (die_temp_c_i < `FLH_TEMP_LO_C) begin
			next_st.hot = 1'b0;
		end
		if (status_clear_i) begin
			next_st.stat = 1'b0;
		end
		// lock: a captured log is not overwritten until erased
		if (erase_req) begin
			next_st.present = 1'b0;
			next_st.erase = 1'b1;
		end else if ((store_req && !st.hot) || real_fault_i) begin
			if (!st.present) begin
				// same capture as a real fault
				next_st.snap.fault_pos = fault_pos_i;
				next_st.snap.uptime = up_if.count;
				next_st.snap.vout_pk = output_voltage_peak_i;
				next_st.snap.iout_pk = output_current_peak_i;
				next_st.snap.iin_pk = channel_input_current_peak_i;
				next_st.snap.vin_pk = input_voltage_peak_i;
				next_st.snap.temp_ext = ext_temp_i;
				next_st.present = 1'b1;
				next_st.store = 1'b1;
			end
			// status bit when logging enabled; set wins
			if (store_req && global_config_word_i[`FLH_CFG_LOG_EN_BIT]) begin
				next_st.stat = 1'b1;
			end
		end
		case (st.rd)
			FLH_IDLE: begin
				if (read_req) begin
					next_st.rd = FLH_LEN;
					next_st.dout = st.present ? `FLH_BLOCK_LEN : 8'h00;
					next_st.idx = 8'h00;
				end
			end
			FLH_LEN: begin
				if (rd_next_i) begin
					if (st.dout == 8'h00) begin
						next_st.rd = FLH_IDLE;
					end else begin
						next_st.rd = FLH_DATA;
						next_st.dout = pick_byte(st.snap, 8'h00, event_byte_i);
					end
				end
			end
			FLH_DATA: begin
				if (rd_next_i) begin
					if (st.idx == `FLH_BLOCK_LEN - 8'h01) begin
						next_st.rd = FLH_IDLE;
					end else begin
						next_st.idx = st.idx + 8'h01;
						next_st.dout = pick_byte(st.snap, st.idx + 8'h01, event_byte_i);
					end
				end
			end
			default: next_st.rd = FLH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_valid_o = st.rd != FLH_IDLE;
	assign rd_data_o = st.dout;
	assign rd_last_o = (st.rd == FLH_LEN && st.dout == 8'h00) ||
		(st.rd == FLH_DATA && st.idx == `FLH_BLOCK_LEN - 8'h01);
	assign status_store_bit_o = st.stat;
	assign nvm_store_o = st.store;
	assign nvm_erase_o = st.erase;
	assign log_present_o = st.present;
	assign hot_lockout_o = st.hot;
	// event pages read their byte using this index (valid in data phase)
	assign event_index_o = (st.rd == FLH_LEN) ? 8'h00 : st.idx + 8'h01;
endmodule : flh_fault_log

// ===== flh_defines.svh
// Purpose: constants for the fault log store and header block
// Assumes: 100 MHz system clock
// Notes: byte numbers count from the first byte after the length byte
`ifndef FLH_DEFINES_SVH
`define FLH_DEFINES_SVH
`define FLH_CMD_FORCE_STORE 8'hEA
`define FLH_CMD_ERASE 8'hEC
`define FLH_CMD_BLOCK_READ 8'hEE
`define FLH_BLOCK_LEN 8'h93
`define FLH_HDR_LAST 8'h13
`define FLH_CFG_LOG_EN_BIT 7
`define FLH_STAT_STORE_BIT 3
`define FLH_TEMP_HI_C 16'sd130
`define FLH_TEMP_LO_C 16'sd125
`define FLH_TICK_NS 200000
`define FLH_CLK_NS 10
`define FLH_TICK_CYC (`FLH_TICK_NS / `FLH_CLK_NS)
`endif

// ===== flh_pkg.sv
// Purpose: types for the fault log store and header block
// Assumes: nothing
// Notes: snapshot layout as captured at the store moment
package flh_pkg;
	typedef enum logic [1:0] {
		FLH_IDLE = 2'b00,
		FLH_LEN = 2'b01,
		FLH_DATA = 2'b10
	} flh_rd_e;
	typedef struct packed {
		logic [7:0] fault_pos;
		logic [47:0] uptime;
		logic [15:0] vout_pk;
		logic [15:0] iout_pk;
		logic [15:0] iin_pk;
		logic [15:0] vin_pk;
		logic [15:0] temp_ext;
	} flh_snap_s;
endpackage : flh_pkg

// ===== flh_uptime_if.sv
// Purpose: carries the uptime count between modules
// Assumes: single clock
// Notes: none
`timescale 1ns/100ps
interface flh_uptime_if;
	logic [47:0] count;
	modport src (output count);
	modport dst (input count);
endinterface : flh_uptime_if

// ===== flh_uptime.sv
// Purpose: 48-bit uptime counter in 200 us steps
// Assumes: reset marks the start of uptime
// Notes: tick is a one-cycle enable from a divider
`timescale 1ns/100ps
`include "flh_defines.svh"
module flh_uptime #(
	parameter int TICK_CYC = `FLH_TICK_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// count out
	flh_uptime_if.src up
);
	typedef struct packed {
		logic [31:0] div;
		logic [47:0] cnt;
	} flh_up_s;
	flh_up_s st;
	flh_up_s next_st;
	initial begin
		if (TICK_CYC < 1) $error("tick count must be at least one");
	end
	always_comb begin
		next_st = st;
		if (st.div == 32'(TICK_CYC - 1)) begin
			next_st.div = 32'h0;
			next_st.cnt = st.cnt + 48'h1;
		end else begin
			next_st.div = st.div + 32'h1;
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign up.count = st.cnt;
endmodule : flh_uptime

// ===== flh_fault_log_sva.sv
// Purpose: port checks for the fault log block
// Assumes: one clock, async high reset
// Notes: sees design ports only
`timescale 1ns/100ps
`include "flh_defines.svh"
module flh_fault_log_sva #(
	parameter int TICK_CYC = 4
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// commands and read
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic cmd_has_data_i,
	input wire logic rd_next_i,
	input wire logic rd_valid_o,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_last_o,
	// status
	input wire logic [7:0] global_config_word_i,
	input wire logic signed [15:0] die_temp_c_i,
	input wire logic real_fault_i,
	input wire logic status_store_bit_o,
	input wire logic nvm_store_o,
	input wire logic nvm_erase_o,
	input wire logic log_present_o,
	input wire logic hot_lockout_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic ea, ee;
	assign ea = cmd_valid_i && cmd_code_i == `FLH_CMD_FORCE_STORE && !cmd_has_data_i;
	assign ee = cmd_valid_i && cmd_code_i == `FLH_CMD_BLOCK_READ && !rd_valid_o;
	a_force_store: assert property (ea && !hot_lockout_o && !log_present_o |=> nvm_store_o && log_present_o) else $error("store not taken");
	a_store_once: assert property (nvm_store_o |=> !nvm_store_o) else $error("store pulse long");
	a_status_set: assert property (ea && !hot_lockout_o && global_config_word_i[7] |=> status_store_bit_o) else $error("status bit");
	a_hot_refuse: assert property (ea && hot_lockout_o && !real_fault_i |=> !nvm_store_o && !$rose(status_store_bit_o)) else $error("hot store");
	a_hot_enter: assert property (die_temp_c_i > `FLH_TEMP_HI_C |=> hot_lockout_o) else $error("no lockout");
	a_hot_band: assert property (hot_lockout_o && die_temp_c_i >= `FLH_TEMP_LO_C |=> hot_lockout_o) else $error("early unlock");
	a_data_refused: assert property (cmd_valid_i && cmd_has_data_i && !real_fault_i |=> !nvm_store_o && !nvm_erase_o) else $error("data taken");
	a_erase_done: assert property (cmd_valid_i && cmd_code_i == `FLH_CMD_ERASE && !cmd_has_data_i && !real_fault_i |=> nvm_erase_o ##[0:1] !log_present_o) else $error("erase");
	a_len_full: assert property (ee && log_present_o |=> rd_valid_o && rd_data_o == `FLH_BLOCK_LEN) else $error("length full");
	a_len_empty: assert property (ee && !log_present_o && !real_fault_i |=> rd_valid_o && rd_last_o && rd_data_o == 8'h00) else $error("length empty");
	a_byte_hold: assert property (rd_valid_o && !rd_next_i |=> $stable(rd_data_o)) else $error("byte moved");
	c_store: cover property (ea ##1 nvm_store_o);
	c_erase: cover property (nvm_erase_o);
	c_full: cover property (rd_valid_o && rd_last_o && log_present_o);
endmodule : flh_fault_log_sva
bind flh_fault_log flh_fault_log_sva #(.TICK_CYC(TICK_CYC)) flh_fault_log_sva_i (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
	.cmd_has_data_i(cmd_has_data_i), .rd_next_i(rd_next_i), .rd_valid_o(rd_valid_o),
	.rd_data_o(rd_data_o), .rd_last_o(rd_last_o), .global_config_word_i(global_config_word_i),
	.die_temp_c_i(die_temp_c_i), .real_fault_i(real_fault_i),
	.status_store_bit_o(status_store_bit_o), .nvm_store_o(nvm_store_o),
	.nvm_erase_o(nvm_erase_o), .log_present_o(log_present_o), .hot_lockout_o(hot_lockout_o));

// ===== flh_host_model.sv
// Purpose: host side issuing commands and block reads
// Assumes: decoder strobe is one cycle
// Notes: two cycles per read byte, slow on purpose
`timescale 1ns/100ps
`include "flh_defines.svh"
module flh_host_model (
	// clock
	input wire logic clk_i,
	// command side
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic cmd_has_data_o,
	// read side
	output logic rd_next_o,
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_data_i
);
	logic [7:0] blk [0:148];
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_has_data_o = 1'b0;
		rd_next_o = 1'b0;
	end
	// send byte, data only for refusal
	task automatic send(input logic [7:0] c, input logic d);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= c;
		cmd_has_data_o <= d;
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_has_data_o <= 1'b0;
	endtask : send
	task automatic read(output int n);
		send(`FLH_CMD_BLOCK_READ, 1'b0);
		#1;
		n = 0;
		while (rd_valid_i === 1'b1 && n < 149) begin
			blk[n] = rd_data_i;
			n++;
			@(posedge clk_i);
			rd_next_o <= 1'b1;
			@(posedge clk_i);
			rd_next_o <= 1'b0;
			#1;
		end
	endtask : read
endmodule : flh_host_model

// ===== tb_fault_log_store_and_header.sv
// Purpose: directed test of store, erase and block read
// Assumes: tick shortened to 4 cycles
// Notes: event bytes follow the index so order shows
`timescale 1ns/100ps
`include "flh_defines.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_fault_log_store_and_header;
	logic clk = 0, rst = 1, cv, hd, rn, rf = 0, sc = 0, rv, rl, st, ns, ne, lp, hot;
	logic [7:0] code, cfg = 8'h00, pos = 8'h5C, ev, idx, rdd;
	logic signed [15:0] temp = 16'sd25;
	logic [15:0] vo = 16'h1234;
	logic [167:0] hdr;
	int n, k, n_mismatch = 0, samples_checked = 0;
	int tt [3] = '{131, 127, 124};
	assign ev = idx + 8'h40;
	assign hdr = {8'h93, pos, 48'h0, vo, 16'h0, 16'hD2AB, 16'hCA01, 16'hE3F0, 16'hEB20, 8'h00};
	flh_fault_log #(.TICK_CYC(4)) flh_fault_log_i (.sys_clk_i(clk), .rst_i(rst),
		.cmd_valid_i(cv), .cmd_code_i(code), .cmd_has_data_i(hd), .rd_next_i(rn),
		.rd_valid_o(rv), .rd_data_o(rdd), .rd_last_o(rl), .global_config_word_i(cfg),
		.die_temp_c_i(temp), .real_fault_i(rf), .fault_pos_i(pos),
		.output_voltage_peak_i(vo), .output_current_peak_i(16'hD2AB),
		.channel_input_current_peak_i(16'hCA01), .input_voltage_peak_i(16'hE3F0),
		.ext_temp_i(16'hEB20), .event_byte_i(ev), .status_clear_i(sc),
		.status_store_bit_o(st), .nvm_store_o(ns), .nvm_erase_o(ne), .log_present_o(lp),
		.hot_lockout_o(hot), .event_index_o(idx));
	flh_host_model flh_host_model_i (.clk_i(clk), .cmd_valid_o(cv), .cmd_code_o(code),
		.cmd_has_data_o(hd), .rd_next_o(rn), .rd_valid_i(rv), .rd_data_i(rdd));
	task wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	initial forever #5 clk = ~clk;
	// a full run is near 650 cycles
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		flh_host_model_i.read(n);
		`CHK(n, 1)
		`CHK(flh_host_model_i.blk[0], 8'h00)
		flh_host_model_i.send(`FLH_CMD_FORCE_STORE, 1'b1);
		#1 `CHK(ns, 1'b0)
		for (k = 0; k < 3; k++) begin
			@(posedge clk) temp <= tt[k][15:0];
			repeat (2) @(posedge clk);
			flh_host_model_i.send(`FLH_CMD_FORCE_STORE, 1'b0);
			#1 `CHK(ns, k == 2)
			`CHK(hot, k != 2)
		end
		`CHK(st, 1'b0)
		`CHK(lp, 1'b1)
		@(posedge clk) cfg <= 8'h80;
		flh_host_model_i.send(`FLH_CMD_FORCE_STORE, 1'b0);
		#1 `CHK(st, 1'b1)
		@(posedge clk) sc <= 1'b1;
		@(posedge clk) sc <= 1'b0;
		#1 `CHK(st, 1'b0)
		flh_host_model_i.read(n);
		`CHK(n, 148)
		for (k = 0; k < 148; k++)
			if (k < 2 || k > 7)
				`CHK(flh_host_model_i.blk[k], k < 21 ? hdr[8 * (20 - k) +: 8] : 8'(k + 8'h3F))
		for (k = 3; k < 8; k++)
			`CHK(flh_host_model_i.blk[k], 8'h00)
		`CHK(flh_host_model_i.blk[2] != 8'h00, 1'b1)
		flh_host_model_i.send(`FLH_CMD_ERASE, 1'b0);
		#1 `CHK(ne, 1'b1)
		flh_host_model_i.read(n);
		`CHK(n, 1)
		@(posedge clk) begin
			vo <= 16'h0BCD;
			rf <= 1'b1;
		end
		@(posedge clk) rf <= 1'b0;
		flh_host_model_i.read(n);
		`CHK(flh_host_model_i.blk[0], 8'h93)
		`CHK(flh_host_model_i.blk[8], 8'h0B)
		`CHK(flh_host_model_i.blk[9], 8'hCD)
		wrap_up();
	end
endmodule : tb_fault_log_store_and_header
